// ===== verilog/ads_pkg.sv
// Purpose: Shared constants for the converter streamer and its carrier end
// Assumes: 200 MHz system clock on both ends
// Notes:   Halfword field positions are for the low half; the high half adds HW_W
// Notes on behaviour
// - Addresses 0/1 hold read/write FIFO numbers
// - Default one A/D, one D/A channel
// - Address 2 bit 0 sets A/D channels
// - Address 3 bit 0 sets D/A channels
// - Full input buffer drops samples, overflow LED
// - First sample after loss carries overflow flag
// - Empty output buffer holds DAC, underflow LED
// - Input buffer has 511 locations
// - One A/D channel: two samples per word
// - Two A/D channels: B high, A low
// - Sampling and update follow AC clock
// - Input buffer drains whenever carrier has space
// - Output buffer has 511 locations
// - One D/A channel: n+1 high, n low
// - Two D/A channels: B high, A low
// - Output buffer fills whenever carrier has data
// - Each AC rising edge updates DAC if data
// - Controller sets FIFOs, then channels, then streams
// - Consumer reads at least at sample rate
package ads_pkg;
    localparam int         CLK_MHZ        = 200;
    localparam int         LED_HOLD_MS    = 100;
    localparam int         LED_HOLD_CYC   = LED_HOLD_MS * CLK_MHZ * 1000;
    localparam int         FIFO_DEPTH     = 511;
    localparam int         WORD_W         = 32;
    localparam int         HW_W           = 16;
    localparam int         SAMPLE_W       = 12;
    localparam int         OVF_BIT        = 14;
    localparam int         TOP_BIT        = 13;
    localparam int         OTR_BIT        = 12;
    localparam int         CHAN_SEL_BIT   = 0;
    localparam logic [1:0] CFG_READ_FIFO  = 2'h0;
    localparam logic [1:0] CFG_WRITE_FIFO = 2'h1;
    localparam logic [1:0] CFG_ADC_CHANS  = 2'h2;
    localparam logic [1:0] CFG_DAC_CHANS  = 2'h3;
    localparam logic [7:0] RST_FIFO_SEL   = 8'h00;
    localparam logic [7:0] RST_CHANS      = 8'h00;
    localparam int         LINK_HALF      = 4;
    localparam logic [1:0] HOST_CFG       = 2'h0;
    localparam logic [1:0] HOST_TX        = 2'h1;
    localparam logic [1:0] HOST_RX        = 2'h2;
    localparam logic [1:0] HOST_STAT      = 2'h3;
    localparam int         CFG_ADDR_LSB   = 8;
    localparam int         STAT_TX_FULL   = 0;
    localparam int         STAT_RX_VALID  = 1;
    localparam int         STAT_CFG_BUSY  = 2;
endpackage

// ===== verilog/ads_if.sv
// Purpose: Carrier FIFO link and configuration message wires
// Assumes: Host end makes link_clk; device end samples everything
// Notes:   Host changes its outputs on link_clk falling edges
`timescale 1ns/1ps
interface ads_if;
    logic        link_clk;
    logic [31:0] h2d_data;
    logic        h2d_valid;
    logic        h2d_space;
    logic        d2h_rd;
    logic [31:0] d2h_data;
    logic        d2h_wr;
    logic        cfg_strobe;
    logic [1:0]  cfg_addr;
    logic [7:0]  cfg_data;
    modport device (input link_clk, h2d_data, h2d_valid, h2d_space, cfg_strobe, cfg_addr, cfg_data,
                    output d2h_rd, d2h_data, d2h_wr);
    modport host   (output link_clk, h2d_data, h2d_valid, h2d_space, cfg_strobe, cfg_addr, cfg_data,
                    input d2h_rd, d2h_data, d2h_wr);
endinterface

// ===== verilog/ads_fifo.sv
// Purpose: Flop-based first-in first-out buffer of any depth
// Assumes: Caller never pushes when full nor pops when empty
// Notes:   Non power-of-two depth, so pointers wrap explicitly
`timescale 1ns/1ps
module ads_fifo
    import ads_pkg::*;
#(
    parameter int W     = WORD_W,
    parameter int DEPTH = FIFO_DEPTH,
    parameter int CW    = $clog2(DEPTH + 1)
)(
    input  wire logic          i_clk,
    input  wire logic          i_rst_b,
    input  wire logic          i_push,
    input  wire logic [W-1:0]  i_data,
    input  wire logic          i_pop,
    output logic      [W-1:0]  o_data,
    output logic               o_empty,
    output logic               o_full,
    output logic      [CW-1:0] o_count
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0]  mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;

    always_ff @(posedge i_clk)
    begin
        if (i_push)
        begin
            mem[wr_ptr] <= i_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wr_ptr  <= '0;
            rd_ptr  <= '0;
            o_count <= '0;
        end
        else
        begin
            if (i_push)
            begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (i_pop)
            begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            o_count <= o_count + CW'(i_push) - CW'(i_pop);
        end
    end

    assign o_data  = mem[rd_ptr];
    assign o_empty = (o_count == '0);
    assign o_full  = (o_count == CW'(DEPTH));
endmodule // ads_fifo

// ===== verilog/ads_device.sv
// Purpose: Converter end: A/D to carrier FIFO, carrier FIFO to D/A
// Assumes: AC clock, link and converter pins are asynchronous to i_clk
// Notes:   All pin inputs pass two flops; edges found on i_clk
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module ads_device
    import ads_pkg::*;
#(
    parameter int LED_HOLD = LED_HOLD_CYC,
    parameter int DEPTH    = FIFO_DEPTH
)(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    ads_if.device            bus,
    input  wire logic        i_ac_clk,
    input  wire logic [11:0] i_adc_a,
    input  wire logic        i_adc_a_over_range,
    input  wire logic [11:0] i_adc_b,
    input  wire logic        i_adc_b_over_range,
    output logic      [15:0] o_dac_a,
    output logic      [15:0] o_dac_b,
    output logic             o_dac_strobe,
    output logic             o_overflow_indicator_led,
    output logic             o_underflow_indicator_led,
    output logic      [7:0]  o_read_fifo_select,
    output logic      [7:0]  o_write_fifo_select
);
    localparam int SYNC_W = 73;
    localparam int CW     = $clog2(DEPTH + 1);
    localparam int LED_CW = $clog2(LED_HOLD + 1);

    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    logic              lk_s;
    logic              valid_s;
    logic [31:0]       hdata_s;
    logic              space_s;
    logic              cstb_s;
    logic [1:0]        caddr_s;
    logic [7:0]        cdata_s;
    logic              ac_s;
    logic              otrb_s;
    logic [11:0]       adcb_s;
    logic              otra_s;
    logic [11:0]       adca_s;
    logic              lk_d;
    logic              ac_d;
    logic              link_rise;
    logic              ac_rise;
    logic [7:0]        adc_chans;
    logic [7:0]        dac_chans;
    logic [15:0]       adc_low;
    logic              half_have;
    logic              ovf_pend;
    logic              adc_push;
    logic [31:0]       adc_word;
    logic [31:0]       in_data;
    logic              in_empty;
    logic              in_full;
    logic              in_pop;
    logic              taken;
    logic              out_push;
    logic              out_pop;
    logic [31:0]       out_data;
    logic              out_empty;
    logic [CW-1:0]     out_count;
    logic [15:0]       dac_hi;
    logic              dac_hi_pend;
    logic [1:0]        event_hit;
    logic [1:0]        led;

    // Only sync2 is read; sync1 may be metastable
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= {bus.link_clk, bus.h2d_valid, bus.h2d_data, bus.h2d_space, bus.cfg_strobe,
                      bus.cfg_addr, bus.cfg_data, i_ac_clk, i_adc_b_over_range, i_adc_b,
                      i_adc_a_over_range, i_adc_a};
            sync2 <= sync1;
        end
    end

    assign {lk_s, valid_s, hdata_s, space_s, cstb_s, caddr_s, cdata_s, ac_s,
            otrb_s, adcb_s, otra_s, adca_s} = sync2;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            lk_d <= 1'b0;
            ac_d <= 1'b0;
        end
        else
        begin
            lk_d <= lk_s;
            ac_d <= ac_s;
        end
    end

    assign link_rise = lk_s & ~lk_d;
    assign ac_rise   = ac_s & ~ac_d;

    // Configuration messages, taken on a link rising edge
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_read_fifo_select  <= RST_FIFO_SEL;
            o_write_fifo_select <= RST_FIFO_SEL;
            adc_chans           <= RST_CHANS;
            dac_chans           <= RST_CHANS;
        end
        else if (link_rise && cstb_s)
        begin
            case (caddr_s)
                CFG_READ_FIFO:  o_read_fifo_select  <= cdata_s;
                CFG_WRITE_FIFO: o_write_fifo_select <= cdata_s;
                CFG_ADC_CHANS:  adc_chans           <= cdata_s;
                CFG_DAC_CHANS:  dac_chans           <= cdata_s;
                default:        o_read_fifo_select  <= o_read_fifo_select;
            endcase
        end
    end

    function automatic logic [15:0] pack_hw(logic [11:0] s, logic over_range_flag, logic ovf);
        logic [15:0] hw;
        hw                 = '0;
        hw[OVF_BIT]        = ovf;
        hw[TOP_BIT]        = s[11] ^ s[10];
        hw[OTR_BIT]        = over_range_flag;
        hw[SAMPLE_W-1:0]   = s;
        return hw;
    endfunction

    // A/D packing on each AC rising edge
    assign adc_push = ac_rise & (adc_chans[CHAN_SEL_BIT] | half_have);
    always_comb
    begin
        if (adc_chans[CHAN_SEL_BIT])
        begin
            adc_word = {pack_hw(adcb_s, otrb_s, ovf_pend), pack_hw(adca_s, otra_s, ovf_pend)};
        end
        else
        begin
            adc_word = {pack_hw(adca_s, otra_s, 1'b0), adc_low};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            adc_low   <= '0;
            half_have <= 1'b0;
        end
        else if (ac_rise)
        begin
            if (adc_chans[CHAN_SEL_BIT] || half_have)
            begin
                half_have <= 1'b0;
            end
            else
            begin
                adc_low   <= pack_hw(adca_s, otra_s, ovf_pend);
                half_have <= 1'b1;
            end
        end
    end

    // Loss sets the flag; a fresh loss beats the clear of a good push
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ovf_pend <= 1'b0;
        end
        else if (adc_push)
        begin
            ovf_pend <= in_full;
        end
    end

    ads_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_in_fifo (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_push  (adc_push & ~in_full),
        .i_data  (adc_word),
        .i_pop   (in_pop),
        .o_data  (in_data),
        .o_empty (in_empty),
        .o_full  (in_full),
        .o_count ()
    );

    // Carrier write side: a word goes whenever the carrier shows space
    assign taken  = bus.d2h_wr & space_s;
    assign in_pop = link_rise & (taken | ~bus.d2h_wr) & ~in_empty;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            bus.d2h_wr   <= 1'b0;
            bus.d2h_data <= '0;
        end
        else if (in_pop)
        begin
            bus.d2h_wr   <= 1'b1;
            bus.d2h_data <= in_data;
        end
        else if (link_rise && taken)
        begin
            bus.d2h_wr <= 1'b0;
        end
    end

    // Carrier read side: rd only while a further word still fits
    assign out_push = link_rise & bus.d2h_rd & valid_s;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            bus.d2h_rd <= 1'b0;
        end
        else if (link_rise)
        begin
            bus.d2h_rd <= ({1'b0, out_count} + (CW + 1)'(out_push)) < (CW + 1)'(DEPTH);
        end
    end

    ads_fifo #(.W(WORD_W), .DEPTH(DEPTH)) u_out_fifo (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_push  (out_push),
        .i_data  (hdata_s),
        .i_pop   (out_pop),
        .o_data  (out_data),
        .o_empty (out_empty),
        .o_full  (),
        .o_count (out_count)
    );

    // D/A update; the held half of a single-channel word goes first
    assign out_pop = ac_rise & ~dac_hi_pend & ~out_empty;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_dac_a      <= '0;
            o_dac_b      <= '0;
            dac_hi       <= '0;
            dac_hi_pend  <= 1'b0;
            o_dac_strobe <= 1'b0;
        end
        else
        begin
            o_dac_strobe <= ac_rise & (dac_hi_pend | ~out_empty);
            if (ac_rise && dac_hi_pend)
            begin
                o_dac_a     <= dac_hi;
                dac_hi_pend <= 1'b0;
            end
            else if (out_pop)
            begin
                o_dac_a <= out_data[HW_W-1:0];
                if (dac_chans[CHAN_SEL_BIT])
                begin
                    o_dac_b <= out_data[WORD_W-1:HW_W];
                end
                else
                begin
                    dac_hi      <= out_data[WORD_W-1:HW_W];
                    dac_hi_pend <= 1'b1;
                end
            end
        end
    end

    // Empty at an update leaves the DAC as it was
    assign event_hit[0] = adc_push & in_full;
    assign event_hit[1] = ac_rise & ~dac_hi_pend & out_empty;

    // One hold timer per indicator, restarted by every event
    for (genvar i = 0; i < 2; i++)
    begin : g_led
        logic [LED_CW-1:0] hold;
        always_ff @(posedge i_clk or negedge i_rst_b)
        begin
            if (!i_rst_b)
            begin
                hold   <= '0;
                led[i] <= 1'b0;
            end
            else
            begin
                if (event_hit[i])
                begin
                    hold <= LED_CW'(LED_HOLD - 1);
                end
                else if (hold != '0)
                begin
                    hold <= hold - 1'b1;
                end
                led[i] <= event_hit[i] | (hold != '0);
            end
        end
    end

    assign o_overflow_indicator_led  = led[0];
    assign o_underflow_indicator_led = led[1];
endmodule // ads_device

// ===== verilog/ads_host.sv
// Purpose: Carrier end: makes the link clock, feeds and drains the device
// Assumes: Software port on i_clk; device pins come back asynchronous
// Notes:   One-word holding registers each way, so one word per link cycle at most
`timescale 1ns/1ps
module ads_host
    import ads_pkg::*;
#(
    parameter int HALF = LINK_HALF
)(
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    ads_if.host              bus,
    input  wire logic [1:0]  i_addr,
    input  wire logic [31:0] i_wdata,
    input  wire logic        i_wr,
    input  wire logic        i_rd,
    output logic      [31:0] o_rdata
);
    localparam int DW = $clog2(HALF + 1);

    logic [33:0]   sync1;
    logic [33:0]   sync2;
    logic          rd_s;
    logic          wr_s;
    logic [31:0]   data_s;
    logic [DW-1:0] div;
    logic          lclk;
    logic          rise;
    logic          fall;
    logic [31:0]   tx_word;
    logic          tx_full;
    logic [31:0]   rx_word;
    logic          rx_valid;
    logic [9:0]    cfg_word;
    logic          cfg_pend;
    logic [31:0]   h_data;
    logic          h_valid;
    logic          h_space;
    logic          h_stb;
    logic [9:0]    h_cfg;

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            sync1 <= '0;
            sync2 <= '0;
        end
        else
        begin
            sync1 <= {bus.d2h_rd, bus.d2h_wr, bus.d2h_data};
            sync2 <= sync1;
        end
    end

    assign {rd_s, wr_s, data_s} = sync2;

    // Link clock by divider; half period HALF cycles
    assign rise = (div == DW'(HALF - 1)) & ~lclk;
    assign fall = (div == DW'(HALF - 1)) & lclk;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            div  <= '0;
            lclk <= 1'b0;
        end
        else if (div == DW'(HALF - 1))
        begin
            div  <= '0;
            lclk <= ~lclk;
        end
        else
        begin
            div <= div + 1'b1;
        end
    end

    // Writes while busy are dropped; status shows busy
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            tx_word  <= '0;
            tx_full  <= 1'b0;
            cfg_word <= '0;
            cfg_pend <= 1'b0;
        end
        else
        begin
            if (rise && h_valid && rd_s)
            begin
                tx_full <= 1'b0;
            end
            else if (i_wr && i_addr == HOST_TX && !tx_full)
            begin
                tx_word <= i_wdata;
                tx_full <= 1'b1;
            end
            if (rise && h_stb)
            begin
                cfg_pend <= 1'b0;
            end
            else if (i_wr && i_addr == HOST_CFG && !cfg_pend)
            begin
                cfg_word <= i_wdata[9:0];
                cfg_pend <= 1'b1;
            end
        end
    end

    // Receive wins over a read clear in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_word  <= '0;
            rx_valid <= 1'b0;
        end
        else if (rise && h_space && wr_s)
        begin
            rx_word  <= data_s;
            rx_valid <= 1'b1;
        end
        else if (i_rd && i_addr == HOST_RX)
        begin
            rx_valid <= 1'b0;
        end
    end

    // Link outputs change only on falling edges
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            h_data  <= '0;
            h_valid <= 1'b0;
            h_space <= 1'b0;
            h_stb   <= 1'b0;
            h_cfg   <= '0;
        end
        else if (fall)
        begin
            h_data  <= tx_word;
            h_valid <= tx_full;
            h_space <= ~rx_valid;
            h_stb   <= cfg_pend;
            h_cfg   <= cfg_word;
        end
    end

    assign bus.link_clk   = lclk;
    assign bus.h2d_data   = h_data;
    assign bus.h2d_valid  = h_valid;
    assign bus.h2d_space  = h_space;
    assign bus.cfg_strobe = h_stb;
    assign bus.cfg_addr   = h_cfg[CFG_ADDR_LSB+1:CFG_ADDR_LSB];
    assign bus.cfg_data   = h_cfg[7:0];

    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_rdata <= '0;
        end
        else if (i_rd)
        begin
            case (i_addr)
                HOST_CFG:  o_rdata <= {22'h000000, cfg_word};
                HOST_TX:   o_rdata <= tx_word;
                HOST_RX:   o_rdata <= rx_word;
                HOST_STAT: o_rdata <= {29'h00000000, cfg_pend, rx_valid, tx_full};
                default:   o_rdata <= '0;
            endcase
        end
        else
        begin
            o_rdata <= '0;
        end
    end
endmodule // ads_host

// ===== testbench/ads_chk.sv
// Purpose: Link wire checks
// Assumes: Host HALF of 4
// Notes:   Plain inputs, no bind
`timescale 1ns/1ps
module ads_chk (
    input  wire logic        i_clk,
    input  wire logic        i_rst_b,
    input  wire logic        link_clk,
    input  wire logic [31:0] h2d_data,
    input  wire logic        h2d_valid,
    input  wire logic        h2d_space,
    input  wire logic        d2h_rd,
    input  wire logic [31:0] d2h_data,
    input  wire logic        d2h_wr,
    input  wire logic        cfg_strobe,
    input  wire logic [1:0]  cfg_addr,
    input  wire logic [7:0]  cfg_data
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    sequence s_hi; link_clk [*4]; endsequence
    sequence s_lo; !link_clk [*4]; endsequence
    property p_period; $rose(link_clk) |-> s_hi ##1 s_lo ##1 link_clk; endproperty
    a_period: assert property (p_period) else $error("link period");
    // Device must not move its word near the sampling rise
    property p_dev_hold;
        $rose(link_clk) |=> ($stable(d2h_data) && $stable(d2h_wr) && $stable(d2h_rd)) [*2];
    endproperty
    a_dev_hold: assert property (p_dev_hold) else $error("device hold");
    property p_h2d; $changed(h2d_data) || $changed(h2d_valid) |-> !link_clk; endproperty
    a_h2d: assert property (p_h2d) else $error("host data edge");
    property p_space; $changed(h2d_space) |-> !link_clk; endproperty
    a_space: assert property (p_space) else $error("space edge");
    property p_cfg_stable; cfg_strobe && $past(cfg_strobe) |-> $stable(cfg_addr) && $stable(cfg_data); endproperty
    a_cfg_stable: assert property (p_cfg_stable) else $error("cfg moved");
    property p_cfg_rise; $rose(cfg_strobe) |-> cfg_strobe throughout (##[1:8] $rose(link_clk)); endproperty
    a_cfg_rise: assert property (p_cfg_rise) else $error("cfg short");
    property p_cfg_end; $rose(cfg_strobe) |-> ##[1:12] !cfg_strobe; endproperty
    a_cfg_end: assert property (p_cfg_end) else $error("cfg long");
    property p_cfg_edge; $changed(cfg_strobe) |-> !link_clk; endproperty
    a_cfg_edge: assert property (p_cfg_edge) else $error("cfg edge");
endmodule // ads_chk

// ===== testbench/tb.sv
// Purpose: Host and device face to face
// Assumes: Short LED hold and depth
// Notes:   Inputs held steady so words repeat
`timescale 1ns/1ps
module tb;
    import ads_pkg::*;
    logic        i_clk   = 1'b0;
    logic        i_rst_b = 1'b0;
    logic        ac      = 1'b0;
    logic [1:0]  addr    = 2'h0;
    logic [31:0] wdata   = 32'h0;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic        rd_d    = 1'b0;
    logic [11:0] adc_a   = 12'h0;
    logic [11:0] adc_b   = 12'h0;
    logic        otr_a   = 1'b0;
    logic        otr_b   = 1'b0;
    logic        seen    = 1'b0;
    logic [31:0] rdata, v, w, ex, mk;
    logic [15:0] dac_a, dac_b, ha, hb;
    logic        stb, ovf, unf;
    logic [7:0]  rsel, wsel;
    int          miscompares = 0;
    int          tests_run   = 0;
    int          seed        = 93640;
    logic [31:0] rd_q[$], rm_q[$], dac_q[$];
    logic        cb_q[$];
    ads_if bus ();
    ads_host i_ads_host (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(bus), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
    ads_device #(.LED_HOLD(50), .DEPTH(4)) i_ads_device (.i_clk(i_clk), .i_rst_b(i_rst_b), .bus(bus),
        .i_ac_clk(ac), .i_adc_a(adc_a), .i_adc_a_over_range(otr_a), .i_adc_b(adc_b),
        .i_adc_b_over_range(otr_b), .o_dac_a(dac_a), .o_dac_b(dac_b), .o_dac_strobe(stb),
        .o_overflow_indicator_led(ovf), .o_underflow_indicator_led(unf),
        .o_read_fifo_select(rsel), .o_write_fifo_select(wsel));
    ads_chk i_ads_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .link_clk(bus.link_clk), .h2d_data(bus.h2d_data),
        .h2d_valid(bus.h2d_valid), .h2d_space(bus.h2d_space), .d2h_rd(bus.d2h_rd), .d2h_data(bus.d2h_data),
        .d2h_wr(bus.d2h_wr), .cfg_strobe(bus.cfg_strobe), .cfg_addr(bus.cfg_addr), .cfg_data(bus.cfg_data));
    initial forever #2.5 i_clk = ~i_clk;
    initial
    begin
        #7;
        forever #24 ac = ~ac;
    end
    task automatic test_done();
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            miscompares++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask
    // Read expectation is queued; mask 0 means a poll
    task automatic xfer(input logic w_n, input logic [1:0] a, input logic [31:0] d, input logic [31:0] m,
                        output logic [31:0] q);
        @(posedge i_clk);
        wr <= w_n;
        rd <= !w_n;
        addr <= a;
        wdata <= d;
        if (!w_n)
        begin
            rd_q.push_back(d);
            rm_q.push_back(m);
        end
        @(posedge i_clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 q = rdata;
    endtask
    task automatic wait_stat(input int b, input logic lv);
        logic [31:0] q;
        for (int n = 0; n < 400; n++)
        begin
            xfer(1'b0, HOST_STAT, 32'h0, 32'h0, q);
            if (q[b] === lv)
                return;
        end
        miscompares++;
        test_done();
    endtask
    task automatic put(input logic [1:0] a, input int b, input logic [31:0] d);
        logic [31:0] q;
        wait_stat(b, 1'b0);
        xfer(1'b1, a, d, 32'h0, q);
        wait_stat(b, 1'b0);
    endtask
    always @(posedge i_clk) rd_d <= rd;
    always @(negedge i_clk)
    begin
        if (rd_d && rd_q.size() > 0)
        begin
            ex = rd_q.pop_front();
            mk = rm_q.pop_front();
            if (mk != 32'h0)
                cmp("rdata", ex & mk, rdata & mk);
        end
        if (stb === 1'b1)
        begin
            if (dac_q.size() == 0)
                cmp("dac_strobe", 32'h0, 32'h1);
            else
            begin
                ex = dac_q.pop_front();
                cmp("dac_a", ex[15:0], dac_a);
                if (cb_q.pop_front())
                    cmp("dac_b", ex[31:16], dac_b);
            end
        end
    end
    initial
    begin
        #400000;
        miscompares++;
        test_done();
    end
    initial
    begin
        repeat (11) @(posedge i_clk);
        cmp("reset", 32'h0, {rsel, wsel, dac_a});
        @(posedge i_clk);
        i_rst_b <= 1'b1;
        v = $random(seed);
        put(HOST_CFG, STAT_CFG_BUSY, {22'h0, CFG_READ_FIFO, v[7:0]});
        put(HOST_CFG, STAT_CFG_BUSY, {22'h0, CFG_WRITE_FIFO, v[15:8]});
        repeat (16) @(posedge i_clk);
        cmp("fifo_sel", {16'h0, v[7:0], v[15:8]}, {16'h0, rsel, wsel});
        repeat (200) @(posedge i_clk);
        cmp("underflow", 32'h10000, {15'h0, unf, dac_a});
        $display("config and underflow done");
        for (int m = 0; m < 2; m++)
        begin
            // First pass runs on the reset channel count
            if (m != 0)
                put(HOST_CFG, STAT_CFG_BUSY, {22'h0, CFG_DAC_CHANS, 7'h0, m[0]});
            for (int k = 0; k < 3; k++)
            begin
                w = $random(seed);
                dac_q.push_back(m ? w : {16'h0, w[15:0]});
                cb_q.push_back(m[0]);
                if (m == 0)
                begin
                    dac_q.push_back({16'h0, w[31:16]});
                    cb_q.push_back(1'b0);
                end
                put(HOST_TX, STAT_TX_FULL, w);
            end
            for (int n = 0; n < 2000 && dac_q.size() > 0; n++)
                @(posedge i_clk);
            cmp("dac_left", 32'h0, dac_q.size());
            $display("dac mode done");
        end
        cmp("overflow", 1'b1, ovf);
        for (int m = 0; m < 2; m++)
        begin
            put(HOST_CFG, STAT_CFG_BUSY, {22'h0, CFG_ADC_CHANS, 7'h0, m[0]});
            @(posedge i_clk);
            adc_a <= 12'($random(seed));
            adc_b <= 12'($random(seed));
            otr_a <= 1'($random(seed));
            otr_b <= 1'($random(seed));
            @(posedge i_clk);
            ha = {2'b00, adc_a[11] ^ adc_a[10], otr_a, adc_a};
            hb = {2'b00, adc_b[11] ^ adc_b[10], otr_b, adc_b};
            // Early words may predate the change
            for (int k = 0; k < 14; k++)
            begin
                wait_stat(STAT_RX_VALID, 1'b1);
                xfer(1'b0, HOST_RX, m ? {hb, ha} : {ha, ha}, k < 10 ? 32'h0 : 32'hBFFF_BFFF, w);
                seen = seen | w[14] | w[30];
            end
            $display("adc mode done");
        end
        cmp("loss_flag", 1'b1, seen);
        test_done();
    end
endmodule // tb
